//--- pkg/ccfg_pkg.sv
// Constants, register layouts and state types for the charger configuration register bank.
// ==========================================================================
// How it works
// - Discharge limit code picks 500, 1000, 1500 mA or no limit; default 1000.
// - Undervoltage code 0-2 gives 3.0 V, then 2.8 V down to 2.0 V; default 2.
// - Charge-state change raises the interrupt only while its mask is clear; reset masked.
// - Input-limit fault interrupt suppressed while its mask is set; reset masked.
// - One mask gates both power management interrupts; reset enabled.
// - Thermistor bit clear stops thermistor charge control only; monitoring stays on.
// - Precharge threshold is 3 V when clear, 2.8 V when set.
// - Timer-slow bit halves the charge timer outside constant-current and constant-voltage.
// - Safety timer code picks 3, 6 or 12 hours, or disables it; default 6.
// - Watchdog restores defaults at 160 s, resets at 160 s or 40 s, or is off.
// - Long-press time is 5, 10, 15 or 20 s; default 10 s.
// - Long-press reset optionally also needs the input supply good.
// - Auto wake restart interval is 0.5, 1, 2 or 4 s; default 1 s.
// - Input current limit codes give 50 to 1100 mA; default 500 mA.
// - Event flags behind the masks clear when they are read.
package ccfg_pkg;

	// ==========================================================================
	// Register map.
	localparam logic [3:0] CCFG_ADDR_DISCH = 4'h6;
	localparam logic [3:0] CCFG_ADDR_DEVCTL = 4'h7;
	localparam logic [3:0] CCFG_ADDR_TMRLIM = 4'h8;
	localparam logic [3:0] CCFG_ADDR_FLAGS = 4'hd;
	localparam logic [7:0] CCFG_DISCH_RST = 8'h56;
	localparam logic [7:0] CCFG_DEVCTL_RST = 8'h84;
	localparam logic [7:0] CCFG_TMRLIM_RST = 8'h4d;

	// ==========================================================================
	// Timing: one slow tick is 100 ms; durations count slow ticks.
	localparam int CCFG_CLK_PERIOD_PS = 5000;
	localparam int CCFG_TICK_MS = 100;
	localparam longint CCFG_TICK_CYCLES = longint'(CCFG_TICK_MS) * 1000000000 / CCFG_CLK_PERIOD_PS;
	localparam int CCFG_WD_LONG_S = 160;
	localparam int CCFG_WD_SHORT_S = 40;
	localparam int CCFG_LPRESS_STEP_S = 5;
	localparam int CCFG_WAKE_BASE_MS = 500;
	localparam int CCFG_SAFETY_BASE_H = 3;
	localparam logic [10:0] CCFG_WD_LONG_T = 11'(CCFG_WD_LONG_S * 1000 / CCFG_TICK_MS);
	localparam logic [10:0] CCFG_WD_SHORT_T = 11'(CCFG_WD_SHORT_S * 1000 / CCFG_TICK_MS);
	localparam logic [7:0] CCFG_LPRESS_T = 8'(CCFG_LPRESS_STEP_S * 1000 / CCFG_TICK_MS);
	localparam logic [5:0] CCFG_WAKE_T = 6'(CCFG_WAKE_BASE_MS / CCFG_TICK_MS);
	localparam logic [19:0] CCFG_SAFETY_T = 20'(CCFG_SAFETY_BASE_H * 3600 * 1000 / CCFG_TICK_MS);

	// ==========================================================================
	// Field codes.
	localparam logic [1:0] CCFG_SEL_OFF = 2'h3;
	localparam logic [1:0] CCFG_WD_RESTORE = 2'h0;
	localparam logic [1:0] CCFG_WD_RESET_SHORT = 2'h2;
	localparam logic [2:0] CCFG_UVLO_FLOOR_CODE = 3'h2;
	localparam logic [11:0] CCFG_UVLO_TOP_MV = 12'hbb8;
	localparam logic [11:0] CCFG_UVLO_STEP_MV = 12'h0c8;
	localparam logic [11:0] CCFG_PRECHG_HI_MV = 12'hbb8;
	localparam logic [11:0] CCFG_PRECHG_LO_MV = 12'haf0;
	localparam logic [10:0] CCFG_DISCH_STEP_MA = 11'h1f4;

	// ==========================================================================
	// Register layouts, most significant field first.
	typedef struct packed {
		logic [1:0] discharge_limit_sel;
		logic [2:0] undervoltage_threshold_sel;
		logic charge_state_irq_mask;
		logic input_limit_irq_mask;
		logic power_mgmt_irq_mask;
	} ccfg_disch_t;

	typedef struct packed {
		logic thermistor_auto_enable;
		logic precharge_threshold_sel;
		logic spare_store;
		logic timer_half_speed_enable;
		logic [1:0] safety_timer_sel;
		logic [1:0] watchdog_sel;
	} ccfg_devctl_t;

	typedef struct packed {
		logic [1:0] long_press_duration_sel;
		logic reset_needs_input_good;
		logic [1:0] wake_restart_interval_sel;
		logic [2:0] input_current_limit_sel;
	} ccfg_tmrlim_t;

	// Events from the analog side, also the layout of the flag register.
	typedef struct packed {
		logic supply_voltage_power_mgmt;
		logic input_voltage_power_mgmt;
		logic input_limit;
		logic charge_state;
	} ccfg_evt_t;

	// Host access port of the serial-bus target.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ccfg_req_t;

	typedef struct packed {
		ccfg_disch_t disch;
		ccfg_devctl_t devctl;
		ccfg_tmrlim_t tmrlim;
		ccfg_evt_t flags;
		logic [7:0] rdata;
		logic irq;
		logic [10:0] wd_cnt;
		logic [7:0] lp_cnt;
		logic lp_done;
		logic [5:0] wake_cnt;
		logic [19:0] safety_cnt;
		logic half_phase;
		logic safety_expired;
		logic wd_restore;
		logic hw_reset;
		logic wake;
	} ccfg_state_t;

	localparam ccfg_state_t CCFG_STATE_RST = '{disch: CCFG_DISCH_RST, devctl: CCFG_DEVCTL_RST,
		tmrlim: CCFG_TMRLIM_RST, default: '0};

endpackage

//--- rtl/ccfg_tick.sv
// Slow tick generator that paces every long timer of the register bank.
`timescale 1ns/1ps
module ccfg_tick #(
	parameter longint CYCLES = ccfg_pkg::CCFG_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	output logic tick
);
	import ccfg_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} ccfg_tick_state_t;

	ccfg_tick_state_t s_q, s_d;

	// ==========================================================================
	// A single-cycle pulse once every CYCLES clocks.
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt >= 32'(CYCLES - 1)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 32'h1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule

//--- rtl/ccfg_regs.sv
// Charger configuration register bank with its timers, masks and decoded settings.
`timescale 1ns/1ps
module ccfg_regs #(
	parameter longint TICK_CYCLES = ccfg_pkg::CCFG_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire ccfg_pkg::ccfg_req_t req,
	output logic [7:0] rdata,
	input wire ccfg_pkg::ccfg_evt_t events,
	input wire logic charging,
	input wire logic phase_cc_cv,
	input wire logic button_held,
	input wire logic input_supply_good,
	output logic irq,
	output logic [10:0] discharge_limit_ma,
	output logic discharge_limit_off,
	output logic [11:0] undervoltage_mv,
	output logic thermistor_charge_ctrl_en,
	output logic thermistor_monitor_en,
	output logic [11:0] precharge_mv,
	output logic [10:0] input_limit_ma,
	output logic safety_expired,
	output logic wd_restore,
	output logic hw_reset,
	output logic wake
);
	import ccfg_pkg::*;

	ccfg_state_t s_q, s_d;
	logic tick;
	logic [10:0] wd_limit;
	logic [7:0] lp_limit;
	logic [5:0] wake_limit;
	logic [19:0] safety_limit;
	logic safety_step;
	ccfg_evt_t unmasked;

	ccfg_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.reset_n(reset_n),
		.tick(tick)
	);

	// ==========================================================================
	// Limits from the selection fields, in slow ticks.
	always_comb begin
		wd_limit = (s_q.devctl.watchdog_sel == CCFG_WD_RESET_SHORT) ? CCFG_WD_SHORT_T : CCFG_WD_LONG_T;
		lp_limit = 8'(CCFG_LPRESS_T * (8'(s_q.tmrlim.long_press_duration_sel) + 8'h1));
		wake_limit = CCFG_WAKE_T << s_q.tmrlim.wake_restart_interval_sel;
		safety_limit = CCFG_SAFETY_T << s_q.devctl.safety_timer_sel;
		// Half speed means only every second tick counts outside CC and CV.
		safety_step = tick && (!s_q.devctl.timer_half_speed_enable || phase_cc_cv || s_q.half_phase);
	end

	// ==========================================================================
	// Main next-state logic: host access, flags, timers.
	always_comb begin
		s_d = s_q;
		s_d.wd_restore = 1'b0;
		s_d.hw_reset = 1'b0;
		s_d.wake = 1'b0;

		// Reads are answered one cycle after the strobe; unmapped reads return zero.
		if (req.rd) begin
			case (req.addr)
				CCFG_ADDR_DISCH: s_d.rdata = s_q.disch;
				CCFG_ADDR_DEVCTL: s_d.rdata = s_q.devctl;
				CCFG_ADDR_TMRLIM: s_d.rdata = s_q.tmrlim;
				CCFG_ADDR_FLAGS: begin
					s_d.rdata = {4'h0, s_q.flags};
					s_d.flags = '0;
				end
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Writes to the three configuration registers; the flag register ignores writes.
		if (req.wr) begin
			case (req.addr)
				CCFG_ADDR_DISCH: s_d.disch = req.wdata;
				CCFG_ADDR_DEVCTL: s_d.devctl = req.wdata;
				CCFG_ADDR_TMRLIM: s_d.tmrlim = req.wdata;
				default: ;
			endcase
		end

		// New events are ORed in after the read clear, so a set wins over a clear.
		s_d.flags = s_d.flags | events;

		// Watchdog: any host write restarts it; the host is trusted to keep writing.
		if (s_q.devctl.watchdog_sel == CCFG_SEL_OFF || req.wr) begin
			s_d.wd_cnt = '0;
		end else if (tick) begin
			if (s_q.wd_cnt >= wd_limit - 11'h1) begin
				s_d.wd_cnt = '0;
				if (s_q.devctl.watchdog_sel == CCFG_WD_RESTORE) begin
					s_d.wd_restore = 1'b1;
					s_d.disch = CCFG_DISCH_RST;
					s_d.devctl = CCFG_DEVCTL_RST;
					s_d.tmrlim = CCFG_TMRLIM_RST;
				end else begin
					s_d.hw_reset = 1'b1;
				end
			end else begin
				s_d.wd_cnt = s_q.wd_cnt + 11'h1;
			end
		end

		// Long press: count while held, fire once, re-arm on release.
		if (!button_held) begin
			s_d.lp_cnt = '0;
			s_d.lp_done = 1'b0;
		end else begin
			if (tick && s_q.lp_cnt < lp_limit) begin
				s_d.lp_cnt = s_q.lp_cnt + 8'h1;
			end
			// With qualification on, the reset waits while held for the supply to turn good.
			if (s_q.lp_cnt >= lp_limit && !s_q.lp_done &&
					(!s_q.tmrlim.reset_needs_input_good || input_supply_good)) begin
				s_d.hw_reset = 1'b1;
				s_d.lp_done = 1'b1;
			end
		end

		// Auto wake restart pulses once per selected interval.
		if (tick) begin
			if (s_q.wake_cnt >= wake_limit - 6'h1) begin
				s_d.wake_cnt = '0;
				s_d.wake = 1'b1;
			end else begin
				s_d.wake_cnt = s_q.wake_cnt + 6'h1;
			end
		end

		// Fast-charge safety timer runs only while charging and is cleared otherwise.
		if (tick) begin
			s_d.half_phase = !s_q.half_phase;
		end
		if (!charging || s_q.devctl.safety_timer_sel == CCFG_SEL_OFF) begin
			s_d.safety_cnt = '0;
			s_d.safety_expired = 1'b0;
		end else if (safety_step && !s_q.safety_expired) begin
			if (s_q.safety_cnt >= safety_limit - 20'h1) begin
				s_d.safety_expired = 1'b1;
			end else begin
				s_d.safety_cnt = s_q.safety_cnt + 20'h1;
			end
		end

		// Interrupt level from pending flags that their masks let through.
		unmasked.charge_state = s_d.flags.charge_state && !s_d.disch.charge_state_irq_mask;
		unmasked.input_limit = s_d.flags.input_limit && !s_d.disch.input_limit_irq_mask;
		unmasked.input_voltage_power_mgmt = s_d.flags.input_voltage_power_mgmt &&
			!s_d.disch.power_mgmt_irq_mask;
		unmasked.supply_voltage_power_mgmt = s_d.flags.supply_voltage_power_mgmt &&
			!s_d.disch.power_mgmt_irq_mask;
		s_d.irq = |unmasked;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= CCFG_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================================
	// Decoded settings for the analog loops, straight from register fields.
	always_comb begin
		discharge_limit_off = (s_q.disch.discharge_limit_sel == CCFG_SEL_OFF);
		discharge_limit_ma = 11'(CCFG_DISCH_STEP_MA * (11'(s_q.disch.discharge_limit_sel) + 11'h1));
		if (s_q.disch.discharge_limit_sel == CCFG_SEL_OFF) begin
			discharge_limit_ma = 11'h000;
		end
		// Codes at or below the floor code all sit at the top threshold.
		if (s_q.disch.undervoltage_threshold_sel <= CCFG_UVLO_FLOOR_CODE) begin
			undervoltage_mv = CCFG_UVLO_TOP_MV;
		end else begin
			undervoltage_mv = 12'(CCFG_UVLO_TOP_MV -
				CCFG_UVLO_STEP_MV * 12'(s_q.disch.undervoltage_threshold_sel - CCFG_UVLO_FLOOR_CODE));
		end
		precharge_mv = s_q.devctl.precharge_threshold_sel ? CCFG_PRECHG_LO_MV : CCFG_PRECHG_HI_MV;
		case (s_q.tmrlim.input_current_limit_sel)
			3'h0: input_limit_ma = 11'h032;
			3'h1: input_limit_ma = 11'h064;
			3'h2: input_limit_ma = 11'h0c8;
			3'h3: input_limit_ma = 11'h12c;
			3'h4: input_limit_ma = 11'h190;
			3'h5: input_limit_ma = 11'h1f4;
			3'h6: input_limit_ma = 11'h2bc;
			default: input_limit_ma = 11'h44c;
		endcase
	end

	// Monitoring never stops; only thermistor-driven charge control follows the bit.
	assign thermistor_charge_ctrl_en = s_q.devctl.thermistor_auto_enable;
	assign thermistor_monitor_en = 1'b1;
	assign rdata = s_q.rdata;
	assign irq = s_q.irq;
	assign safety_expired = s_q.safety_expired;
	assign wd_restore = s_q.wd_restore;
	assign hw_reset = s_q.hw_reset;
	assign wake = s_q.wake;
endmodule

//--- bench/ccfg_regs_props.sv
// Concurrent checks on the port behaviour of the charger configuration register bank.
`timescale 1ns/1ps
module ccfg_regs_chk
	import ccfg_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire ccfg_pkg::ccfg_req_t req,
	input wire logic [7:0] rdata,
	input wire ccfg_pkg::ccfg_evt_t events,
	input wire logic charging,
	input wire logic irq,
	input wire logic [10:0] discharge_limit_ma,
	input wire logic discharge_limit_off,
	input wire logic [11:0] undervoltage_mv,
	input wire logic thermistor_charge_ctrl_en,
	input wire logic thermistor_monitor_en,
	input wire logic [11:0] precharge_mv,
	input wire logic [10:0] input_limit_ma,
	input wire logic safety_expired,
	input wire logic wd_restore,
	input wire logic hw_reset,
	input wire logic wake
);
	// ==========================================================================
	// Properties; all share the one clock and reset.
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_dis; req.wr && req.addr == 4'h6 |=> discharge_limit_off == ($past(req.wdata[7:6]) == 2'h3) &&
		discharge_limit_ma == (discharge_limit_off ? 11'd0 : 11'd500 * ($past(req.wdata[7:6]) + 2'h1)); endproperty
	a_dis: assert property (p_dis) else $error("discharge limit decode wrong");
	property p_uv; req.wr && req.addr == 4'h6 |=> undervoltage_mv == (($past(req.wdata[5:3]) < 3'h3) ? 12'd3000 :
		12'd3400 - 12'd200 * $past(req.wdata[5:3])); endproperty
	a_uv: assert property (p_uv) else $error("undervoltage decode wrong");
	property p_ts; req.wr && req.addr == 4'h7 |=> thermistor_charge_ctrl_en == $past(req.wdata[7]); endproperty
	a_ts: assert property (p_ts) else $error("thermistor control bit wrong");
	property p_mon; thermistor_monitor_en; endproperty
	a_mon: assert property (p_mon) else $error("thermistor monitor off");
	property p_pre; req.wr && req.addr == 4'h7 |=> precharge_mv == ($past(req.wdata[6]) ? 12'd2800 : 12'd3000); endproperty
	a_pre: assert property (p_pre) else $error("precharge threshold wrong");
	property p_ilim; input_limit_ma inside {11'd50, 11'd100, 11'd200, 11'd300, 11'd400, 11'd500, 11'd700, 11'd1100}; endproperty
	a_ilim: assert property (p_ilim) else $error("input limit out of table");
	// The host leaves one idle cycle between accesses, so two flag reads sit two edges apart.
	property p_clr; (req.rd && req.addr == 4'hd && events == 4'h0) ##1 (events == 4'h0) ##1
		(req.rd && req.addr == 4'hd && events == 4'h0) |=> rdata == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("flags not cleared by read");
	property p_idle; (req.rd && req.addr == 4'hd && events == 4'h0) ##1 (events == 4'h0) |=> !irq; endproperty
	a_idle: assert property (p_idle) else $error("irq without pending flag");
	property p_mask; req.wr && req.addr == 4'h6 && req.wdata[2:0] == 3'h7 |=> ##1 !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq despite all masks");
	property p_hold; !req.rd |=> $stable(rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_pulse; wd_restore || hw_reset || wake |=> !wd_restore && !hw_reset && !wake; endproperty
	a_pulse: assert property (p_pulse) else $error("timer pulse too long");
	property p_safe; !charging |=> !safety_expired; endproperty
	a_safe: assert property (p_safe) else $error("safety expiry while idle");
endmodule

//--- bench/ccfg_host.sv
// Host-side model that issues register accesses on the bank's request port.
`timescale 1ns/1ps
module ccfg_host
	import ccfg_pkg::*;
(
	input wire logic clock,
	output ccfg_pkg::ccfg_req_t req,
	input wire logic [7:0] rdata
);
	// ==========================================================================
	// Each access holds its strobe for exactly one sampling edge.
	initial req = '0;
	task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask
	// Read data is registered, so it is taken just after the sampling edge.
	task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
endmodule

//--- bench/tb_charger_config_registers.sv
// Self-checking bench for the charger configuration register bank.
`timescale 1ns/1ps
module tb_charger_config_registers;
	import ccfg_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	ccfg_req_t req;
	ccfg_evt_t events = '0;
	logic charging = 1'b0;
	logic phase_cc_cv = 1'b0;
	logic button_held = 1'b0;
	logic input_supply_good = 1'b0;
	logic [7:0] rdata;
	logic irq, discharge_limit_off, thermistor_charge_ctrl_en, thermistor_monitor_en;
	logic safety_expired, wd_restore, hw_reset, wake;
	logic [10:0] discharge_limit_ma, input_limit_ma;
	logic [11:0] undervoltage_mv, precharge_mv;
	int bad_count = 0;
	int checked = 0;
	int n;
	logic [7:0] rd;
	logic [10:0] ilim_ma [8] = '{11'd50, 11'd100, 11'd200, 11'd300, 11'd400, 11'd500, 11'd700, 11'd1100};
	// A short tick keeps the watchdog and press timers within a brief run.
	ccfg_regs #(.TICK_CYCLES(4)) u_ccfg_regs (.*);
	ccfg_host u_ccfg_host (.clock(clock), .req(req), .rdata(rdata));
	initial forever #2.5 clock = ~clock;
	// ==========================================================================
	// Shared helpers.
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		u_ccfg_host.read_reg(a, rd);
		chk({4'h0, rd}, {4'h0, e});
	endtask
	task automatic ev(input logic [3:0] v);
		@(posedge clock);
		events <= v;
		@(posedge clock);
		events <= '0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// Counts edges until the chosen pulse shows; sel 0 hw_reset, 1 wake, 2 restore.
	task automatic wait_pulse(input int sel, input int lim, output int c);
		c = 0;
		while (!(sel == 0 ? hw_reset : sel == 1 ? wake : wd_restore) && c < lim) begin
			@(posedge clock);
			#1 c++;
		end
	endtask
	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rd_chk(4'h6, 8'h56);
		rd_chk(4'h7, 8'h84);
		rd_chk(4'h8, 8'h4d);
		rd_chk(4'h0, 8'h00);
		u_ccfg_host.write_reg(4'h7, 8'h43);
		#1 chk({11'h0, thermistor_charge_ctrl_en}, 12'h0);
		chk(precharge_mv, 12'd2800);
		rd_chk(4'h7, 8'h43);
		for (int i = 0; i < 8; i++) begin
			u_ccfg_host.write_reg(4'h6, {i[1:0], i[2:0], 3'h7});
			u_ccfg_host.write_reg(4'h8, {5'h09, i[2:0]});
			#1 chk({1'b0, discharge_limit_ma}, (i[1:0] == 2'h3) ? 12'd0 : 12'd500 * (i[1:0] + 12'd1));
			chk(undervoltage_mv, (i < 3) ? 12'd3000 : 12'd3400 - 12'd200 * i[2:0]);
			chk({1'b0, input_limit_ma}, {1'b0, ilim_ma[i]});
			rd_chk(4'h8, {5'h09, i[2:0]});
		end
		// All masks set: events must only latch flags.
		ev(4'hf);
		chk({11'h0, irq}, 12'h0);
		rd_chk(4'hd, 8'h0f);
		rd_chk(4'hd, 8'h00);
		for (int k = 0; k < 4; k++) begin
			u_ccfg_host.write_reg(4'h6, {5'h0a, (k == 0) ? 3'h3 : (k == 1) ? 3'h5 : 3'h6});
			ev(4'h1 << k);
			chk({11'h0, irq}, 12'h1);
			rd_chk(4'hd, 8'h01 << k);
			@(posedge clock);
			#1 chk({11'h0, irq}, 12'h0);
		end
		// Long press with and without the supply qualification.
		u_ccfg_host.write_reg(4'h8, 8'h0d);
		button_held <= 1'b1;
		wait_pulse(0, 400, n);
		chk({11'h0, n >= 195 && n <= 208}, 12'h1);
		button_held <= 1'b0;
		u_ccfg_host.write_reg(4'h8, 8'h2d);
		button_held <= 1'b1;
		wait_pulse(0, 300, n);
		chk(12'(n), 12'd300);
		input_supply_good <= 1'b1;
		wait_pulse(0, 20, n);
		chk({11'h0, n < 20}, 12'h1);
		button_held <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			u_ccfg_host.write_reg(4'h8, {3'h0, s[1:0], 3'h5});
			wait_pulse(1, 200, n);
			@(posedge clock);
			#1 wait_pulse(1, 200, n);
			chk(12'(n), 12'(20 << s) - 12'd1);
		end
		// Watchdog: short hardware reset, then restore of defaults.
		u_ccfg_host.write_reg(4'h7, 8'h86);
		charging <= 1'b1;
		wait_pulse(0, 1700, n);
		chk({11'h0, safety_expired}, 12'h0);
		charging <= 1'b0;
		chk({11'h0, n >= 1590 && n <= 1606}, 12'h1);
		u_ccfg_host.write_reg(4'h7, 8'h84);
		u_ccfg_host.write_reg(4'h6, 8'h00);
		wait_pulse(2, 6500, n);
		chk({11'h0, n >= 6385 && n <= 6406}, 12'h1);
		rd_chk(4'h6, 8'h56);
		finish_test();
	end
	initial begin
		repeat (40000) @(posedge clock);
		bad_count++;
		finish_test();
	end
endmodule
bind ccfg_regs ccfg_regs_chk u_chk (.*);
